// *** pkg/bdbg_pkg.sv ***
/*
 * Shared constants for the debug-pin sync handshake and simple breakpoint.
 * Assumes both ends run on one 100 MHz clock, clk_sys.
 */
`default_nettype none
package bdbg_pkg;
	// ************************************************************
	// Sync handshake timing, in debug clock cycles
	// ************************************************************
	localparam int unsigned SYNC_REQ_LOW_CYC   = 128;  // Host low phase, slowest clock
	localparam int unsigned SYNC_DETECT_CYC    = 64;   // Target threshold for a request
	localparam int unsigned SYNC_WAIT_CYC      = 16;   // Target delay after pin high
	localparam int unsigned SYNC_RESP_LOW_CYC  = 128;  // Target response low width
	localparam int unsigned SYNC_SPEEDUP_CYC   = 1;    // Speed-up pulse width
	localparam int unsigned SYNC_TIMEOUT_CYC   = 1024; // Host gives up on no response
	localparam int unsigned CNT_W              = 11;
	// ************************************************************
	// Breakpoint reset values
	// ************************************************************
	localparam logic [15:0] BKPT_MATCH_RST     = 16'h0000;
	localparam logic        BKPT_ENABLE_RST    = 1'b0;
	localparam logic        BKPT_FTS_RST       = 1'b0;
endpackage
`default_nettype wire

// *** pkg/bdbg_if.sv ***
/*
 * Single-wire debug pin between host pod and target.
 * Assumes the testbench resolves the wire: low if any end drives low,
 * high if any drives high, else pulled high.
 */
`timescale 1ns/1ns
`default_nettype none
interface bdbg_if;
	// Host side pin
	logic hostOut;
	logic hostOeN;
	// Target side pin
	logic tgtOut;
	logic tgtOeN;
	// Resolved level seen by both
	logic pinIn;
	modport target (input pinIn, output tgtOut, output tgtOeN);
	modport host   (input pinIn, output hostOut, output hostOeN);
endinterface
`default_nettype wire

// *** verilog/bdbg_target.sv ***
/*
 * Target end: sync response on the debug pin and the simple breakpoint.
 * Assumes the pin level is synchronous to clk_sys and the CPU provides
 * an access strobe, an opcode-fetch flag and an instruction-queue tag.
 */
// Contract
// - Host holds pin low 128 slow cycles
// - Host drives brief high, then releases
// - Host watches pin for response pulse
// - Long low is request; await high
// - Wait 16 cycles after pin high
// - Drive pin low 128 cycles
// - Drive one-cycle high, then release
// - Host times low width for bit rate
// - Compare address with match every access
// - Forced: any access breaks at boundary
// - Tagged: tagged opcode breaks at queue end
// - No breakpoint unless enable is set
// - Select bit one forced, zero tagged
`timescale 1ns/1ns
`default_nettype none
module bdbg_target
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	// Debug pin
	bdbg_if.target           dbgPin,
	// Breakpoint setup
	input  wire logic        bkptLoad,
	input  wire logic [15:0] bkptMatchIn,
	input  wire logic        bkptEnableIn,
	input  wire logic        forceTagIn,
	// CPU bus
	input  wire logic [15:0] cpuAddr,
	input  wire logic        cpuAccess,
	input  wire logic        cpuOpFetch,
	input  wire logic        cpuInstrBoundary,
	input  wire logic        cpuQueueEndTag,
	// Status and requests
	output logic             syncBusy,
	output logic             fetchTag,
	output logic             backgroundReq
);
	// ************************************************************
	// Sync response machine
	// ************************************************************
	typedef enum logic [2:0] {ST_IDLE, ST_LOWCNT, ST_WAITHI, ST_DELAY, ST_RESP, ST_SPEEDUP} bdbg_tst_t;
	bdbg_tst_t             state_r, state_nxt;
	logic [bdbg_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
	logic                  oeN_r, oeN_nxt;
	logic                  out_r, out_nxt;

	// Next-state for the sync response
	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		oeN_nxt   = 1'b1;
		out_nxt   = 1'b1;
		case (state_r)
			ST_IDLE:
			begin
				cnt_nxt = '0;
				if (!dbgPin.pinIn)
					state_nxt = ST_LOWCNT;
			end
			ST_LOWCNT:
			begin
				// Short lows are ordinary traffic, so restart on high
				if (dbgPin.pinIn)
					state_nxt = ST_IDLE;
				else if (cnt_r == bdbg_pkg::CNT_W'(bdbg_pkg::SYNC_DETECT_CYC - 2))
					state_nxt = ST_WAITHI;
				else
					cnt_nxt = cnt_r + 1'b1;
			end
			ST_WAITHI:
			begin
				cnt_nxt = '0;
				if (dbgPin.pinIn)
					state_nxt = ST_DELAY;
			end
			ST_DELAY:
			begin
				if (cnt_r == bdbg_pkg::CNT_W'(bdbg_pkg::SYNC_WAIT_CYC - 1))
				begin
					state_nxt = ST_RESP;
					cnt_nxt   = '0;
					oeN_nxt   = 1'b0;
					out_nxt   = 1'b0;
				end
				else
					cnt_nxt = cnt_r + 1'b1;
			end
			ST_RESP:
			begin
				oeN_nxt = 1'b0;
				if (cnt_r == bdbg_pkg::CNT_W'(bdbg_pkg::SYNC_RESP_LOW_CYC - 1))
				begin
					state_nxt = ST_SPEEDUP;
					out_nxt   = 1'b1;
				end
				else
				begin
					out_nxt = 1'b0;
					cnt_nxt = cnt_r + 1'b1;
				end
			end
			ST_SPEEDUP:
				state_nxt = ST_IDLE; // Release after one cycle
			default:
				state_nxt = ST_IDLE;
		endcase
	end

	// Registers for the sync response
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			state_r <= ST_IDLE;
			cnt_r   <= '0;
			oeN_r   <= 1'b1;
			out_r   <= 1'b1;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			oeN_r   <= oeN_nxt;
			out_r   <= out_nxt;
		end
	end

	assign dbgPin.tgtOut = out_r;
	assign dbgPin.tgtOeN = oeN_r;
	assign syncBusy      = (state_r == ST_DELAY) || (state_r == ST_RESP) ||
	                       (state_r == ST_SPEEDUP);

	// ************************************************************
	// Simple hardware breakpoint
	// ************************************************************
	logic [15:0] match_r, match_nxt;
	logic        en_r, en_nxt;
	logic        fts_r, fts_nxt;
	logic        pend_r, pend_nxt;
	logic        tag_r, tag_nxt;
	logic        req_r, req_nxt;
	logic        hit;

	// Address compare on every access
	assign hit = cpuAccess && (cpuAddr == match_r) && en_r;

	// Next values for breakpoint state
	always_comb
	begin
		match_nxt = match_r;
		en_nxt    = en_r;
		fts_nxt   = fts_r;
		if (bkptLoad)
		begin
			match_nxt = bkptMatchIn;
			en_nxt    = bkptEnableIn;
			fts_nxt   = forceTagIn;
		end
		// Forced hit waits for the next instruction boundary
		pend_nxt = pend_r;
		// Boundary consumes any hit, so one access gives one request
		if (!en_r || !fts_r)
			pend_nxt = 1'b0;
		else if (cpuInstrBoundary)
			pend_nxt = 1'b0;
		else if (hit)
			pend_nxt = 1'b1;
		// Tag travels with the fetched opcode
		tag_nxt = hit && !fts_r && cpuOpFetch;
		req_nxt = 1'b0;
		if (en_r && fts_r && (pend_r || hit) && cpuInstrBoundary)
			req_nxt = 1'b1;
		else if (en_r && !fts_r && cpuQueueEndTag)
			req_nxt = 1'b1;
	end

	// Registers for the breakpoint
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			match_r <= bdbg_pkg::BKPT_MATCH_RST;
			en_r    <= bdbg_pkg::BKPT_ENABLE_RST;
			fts_r   <= bdbg_pkg::BKPT_FTS_RST;
			pend_r  <= 1'b0;
			tag_r   <= 1'b0;
			req_r   <= 1'b0;
		end
		else
		begin
			match_r <= match_nxt;
			en_r    <= en_nxt;
			fts_r   <= fts_nxt;
			pend_r  <= pend_nxt;
			tag_r   <= tag_nxt;
			req_r   <= req_nxt;
		end
	end

	assign fetchTag      = tag_r;
	assign backgroundReq = req_r;
endmodule
`default_nettype wire

// *** verilog/bdbg_host.sv ***
/*
 * Host pod end: issues the sync request and times the response.
 * Assumes the target shares clk_sys and the pin resolves as a pulled-up wire.
 */
`timescale 1ns/1ns
`default_nettype none
module bdbg_host
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	// Debug pin
	bdbg_if.host             dbgPin,
	// User command
	input  wire logic        syncStart,
	// Result
	output logic             syncDone,
	output logic             syncTimeout,
	output logic [10:0]      lowWidth
);
	typedef enum logic [2:0] {SH_IDLE, SH_LOW, SH_SPEEDUP, SH_WAITLO, SH_MEASURE} bdbg_hst_t;
	bdbg_hst_t   state_r, state_nxt;
	logic [10:0] cnt_r, cnt_nxt;
	logic [10:0] width_r, width_nxt;
	logic        done_r, done_nxt;
	logic        tout_r, tout_nxt;

	// ************************************************************
	// Request and measurement machine
	// ************************************************************
	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r + 1'b1;
		width_nxt = width_r;
		done_nxt  = 1'b0;
		tout_nxt  = 1'b0;
		case (state_r)
			SH_IDLE:
			begin
				cnt_nxt = '0;
				if (syncStart)
					state_nxt = SH_LOW;
			end
			SH_LOW:
				if (cnt_r == 11'(bdbg_pkg::SYNC_REQ_LOW_CYC - 1))
					state_nxt = SH_SPEEDUP;
			SH_SPEEDUP:
			begin
				state_nxt = SH_WAITLO; // Release after one cycle
				cnt_nxt   = '0;
			end
			SH_WAITLO:
			begin
				if (!dbgPin.pinIn)
				begin
					state_nxt = SH_MEASURE;
					cnt_nxt   = 11'd1;
				end
				else if (cnt_r == 11'(bdbg_pkg::SYNC_TIMEOUT_CYC - 1))
				begin
					state_nxt = SH_IDLE;
					tout_nxt  = 1'b1;
				end
			end
			SH_MEASURE:
				if (dbgPin.pinIn)
				begin
					state_nxt = SH_IDLE;
					width_nxt = cnt_r;
					done_nxt  = 1'b1;
				end
			default:
				state_nxt = SH_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			state_r <= SH_IDLE;
			cnt_r   <= '0;
			width_r <= '0;
			done_r  <= 1'b0;
			tout_r  <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			width_r <= width_nxt;
			done_r  <= done_nxt;
			tout_r  <= tout_nxt;
		end
	end

	// Pin drive: low phase then one high cycle, else released
	assign dbgPin.hostOeN = !((state_r == SH_LOW) || (state_r == SH_SPEEDUP));
	assign dbgPin.hostOut = (state_r == SH_SPEEDUP);
	assign syncDone       = done_r;
	assign syncTimeout    = tout_r;
	assign lowWidth       = width_r;
endmodule
`default_nettype wire

// *** testbench/bdbg_properties.sv ***
/*
 * Pin timing checks for the sync handshake.
 * Assumes it is instantiated beside the interface, fed its plain signals.
 */
`timescale 1ns/1ns
`default_nettype none
module bdbg_properties
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Pin
	input wire logic hostOut,
	input wire logic hostOeN,
	input wire logic tgtOut,
	input wire logic tgtOeN,
	input wire logic pinIn
);
	// ************************************************************
	// Helper counters
	// ************************************************************
	logic [8:0] lowCnt_r;
	logic [8:0] lowCnt_nxt;
	logic [8:0] hiCnt_r;
	logic [8:0] hiCnt_nxt;
	logic [6:0] reqCnt_r;
	logic [6:0] reqCnt_nxt;
	logic       seen_r;
	logic       seen_nxt;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// Saturate so long idle never wraps
	always_comb
	begin
		lowCnt_nxt = (!tgtOeN && !tgtOut) ? lowCnt_r + 9'h1 : 9'h0;
		hiCnt_nxt = (pinIn && tgtOeN) ? hiCnt_r + {8'h0, hiCnt_r != 9'h1ff} : 9'h0;
		reqCnt_nxt = (!pinIn && tgtOeN) ? reqCnt_r + {6'h0, reqCnt_r != 7'h40} : 7'h0;
		seen_nxt = (reqCnt_r == 7'h40) || (seen_r && tgtOeN);
	end
	// Registers only
	always_ff @(posedge clk_sys)
	begin
		lowCnt_r <= sys_rst ? 9'h0 : lowCnt_nxt;
		hiCnt_r <= sys_rst ? 9'h0 : hiCnt_nxt;
		reqCnt_r <= sys_rst ? 7'h0 : reqCnt_nxt;
		seen_r <= sys_rst ? 1'b0 : seen_nxt;
	end
	property p_hostLow; $fell(hostOeN) |-> (!hostOut && !hostOeN)[*8]; endproperty
	a_hostLow: assert property (p_hostLow) else $error("host low short");
	property p_hostRel; !hostOeN && hostOut |=> hostOeN; endproperty
	a_hostRel: assert property (p_hostRel) else $error("host no release");
	property p_wait; tgtOeN && !pinIn |=> tgtOeN; endproperty
	a_wait: assert property (p_wait) else $error("drove during low");
	property p_req; $fell(tgtOeN) |-> seen_r; endproperty
	a_req: assert property (p_req) else $error("answer without request");
	property p_delay; $fell(tgtOeN) |-> hiCnt_r >= 9'h10 && hiCnt_r <= 9'h12; endproperty
	a_delay: assert property (p_delay) else $error("delay wrong");
	property p_first; $fell(tgtOeN) |-> !tgtOut; endproperty
	a_first: assert property (p_first) else $error("answer not low");
	property p_width; !tgtOeN && tgtOut |-> lowCnt_r == 9'h80; endproperty
	a_width: assert property (p_width) else $error("low width wrong");
	property p_rel; !tgtOeN && $rose(tgtOut) |=> tgtOeN; endproperty
	a_rel: assert property (p_rel) else $error("speedup not one");
endmodule
`default_nettype wire

// *** testbench/bdbg_sync_and_breakpoint_tb.sv ***
/*
 * Bench for host and target joined on one pin, plus breakpoint.
 * Assumes the bench resolves the pin as a pulled-up wire.
 */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_total++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module bdbg_sync_and_breakpoint_tb;
	logic        clk_sys = 1'b0;
	logic        sys_rst = 1'b1;
	logic        syncStart = 1'b0;
	logic        tbLow = 1'b0;
	logic        tbCut = 1'b0;
	logic        bkptLoad, bkptEnableIn, forceTagIn, cpuAccess, cpuOpFetch;
	logic        cpuInstrBoundary, cpuQueueEndTag;
	logic [15:0] bkptMatchIn, cpuAddr;
	logic        syncBusy, fetchTag, backgroundReq, syncDone, syncTimeout;
	logic [10:0] lowWidth;
	int          err_total, cmp_count, cycles, bgCnt, tagCnt, tgtLow, tgtHi, hostLow, n;
	int          busyCnt;
	bdbg_if dbgBus();
	always #5 clk_sys = ~clk_sys;
	// Bench low fakes a glitch; cut hides the target drive from the wire
	assign dbgBus.pinIn = ~((!dbgBus.hostOeN && !dbgBus.hostOut) ||
		(!dbgBus.tgtOeN && !dbgBus.tgtOut && !tbCut) || tbLow);
	bdbg_target bdbg_target_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .dbgPin(dbgBus),
		.bkptLoad(bkptLoad), .bkptMatchIn(bkptMatchIn), .bkptEnableIn(bkptEnableIn),
		.forceTagIn(forceTagIn), .cpuAddr(cpuAddr), .cpuAccess(cpuAccess),
		.cpuOpFetch(cpuOpFetch), .cpuInstrBoundary(cpuInstrBoundary),
		.cpuQueueEndTag(cpuQueueEndTag), .syncBusy(syncBusy), .fetchTag(fetchTag),
		.backgroundReq(backgroundReq));
	bdbg_host bdbg_host_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .dbgPin(dbgBus),
		.syncStart(syncStart), .syncDone(syncDone), .syncTimeout(syncTimeout),
		.lowWidth(lowWidth));
	bdbg_properties bdbg_properties_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.hostOut(dbgBus.hostOut), .hostOeN(dbgBus.hostOeN), .tgtOut(dbgBus.tgtOut),
		.tgtOeN(dbgBus.tgtOeN), .pinIn(dbgBus.pinIn));
	// Count pulses mid-cycle, clear of edge races
	always @(negedge clk_sys)
	begin
		bgCnt += (backgroundReq === 1'b1);
		tagCnt += (fetchTag === 1'b1);
		tgtLow += (dbgBus.tgtOeN === 1'b0 && dbgBus.tgtOut === 1'b0);
		tgtHi += (dbgBus.tgtOeN === 1'b0 && dbgBus.tgtOut === 1'b1);
		hostLow += (dbgBus.hostOeN === 1'b0 && dbgBus.hostOut === 1'b0);
		busyCnt += (syncBusy === 1'b1);
	end
	// Hang guard
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			err_total++;
			results();
		end
	end
	task results;
		$display("errors=%0d compares=%0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task load(input logic [15:0] m, input logic e, input logic f);
		@(posedge clk_sys) {bkptMatchIn, bkptEnableIn, forceTagIn, bkptLoad} <= {m, e, f, 1'b1};
		@(posedge clk_sys) bkptLoad <= 1'b0;
	endtask
	// Access, then boundary, then queue end
	task acc(input logic [15:0] a, input logic op);
		bgCnt = 0;
		tagCnt = 0;
		@(posedge clk_sys) {cpuAddr, cpuAccess, cpuOpFetch} <= {a, 1'b1, op};
		@(posedge clk_sys) {cpuAccess, cpuOpFetch, cpuInstrBoundary} <= 3'h1;
		@(posedge clk_sys) {cpuInstrBoundary, cpuQueueEndTag} <= 2'h1;
		@(posedge clk_sys) cpuQueueEndTag <= 1'b0;
		repeat (3) @(posedge clk_sys);
	endtask
	initial
	begin
		{bkptLoad, bkptEnableIn, forceTagIn, cpuAccess, cpuOpFetch} = 5'h0;
		{cpuInstrBoundary, cpuQueueEndTag, bkptMatchIn, cpuAddr} = 34'h0;
		repeat (16) @(posedge clk_sys);
		sys_rst <= 1'b0;
		{tgtLow, tgtHi, hostLow, busyCnt, n} = 0;
		@(posedge clk_sys) syncStart <= 1'b1;
		@(posedge clk_sys) syncStart <= 1'b0;
		do
		begin
			@(negedge clk_sys);
			n++;
		end while (syncDone !== 1'b1 && n < 1200);
		`CHK(syncDone, 1'b1)
		`CHK(lowWidth inside {[11'h7f:11'h81]}, 1'b1)
		repeat (4) @(negedge clk_sys);
		`CHK(hostLow, 128)
		`CHK(tgtLow, 128)
		`CHK(tgtHi, 1)
		`CHK(busyCnt, 16 + 128 + 1)
		// Glitch under the detect threshold must be ignored
		tgtLow = 0;
		@(posedge clk_sys) tbLow <= 1'b1;
		repeat (40) @(posedge clk_sys);
		tbLow <= 1'b0;
		repeat (200) @(posedge clk_sys);
		`CHK(tgtLow, 0)
		// Target cut off: host gives up, target still answers unseen
		@(posedge clk_sys) {tbCut, syncStart} <= 2'h3;
		@(posedge clk_sys) syncStart <= 1'b0;
		n = 0;
		do
		begin
			@(negedge clk_sys);
			n++;
		end while (syncTimeout !== 1'b1 && n < 1400);
		`CHK(syncTimeout, 1'b1)
		`CHK(tgtLow, 128)
		@(posedge clk_sys) tbCut <= 1'b0;
		load(16'h1234, 1'b0, 1'b1);
		acc(16'h1234, 1'b1);
		`CHK(bgCnt + tagCnt, 0)
		load(16'h1234, 1'b1, 1'b1);
		acc(16'h1235, 1'b0);
		`CHK(bgCnt, 0)
		acc(16'h1234, 1'b0);
		`CHK(bgCnt, 1)
		`CHK(tagCnt, 0)
		load(16'h1234, 1'b1, 1'b0);
		acc(16'h1235, 1'b1);
		`CHK(tagCnt, 0)
		acc(16'h1234, 1'b1);
		`CHK(tagCnt, 1)
		`CHK(bgCnt, 1)
		results();
	end
endmodule
`default_nettype wire
